// ==== rtl/vcc_map.svh ====
`ifndef VCC_MAP_SVH
`define VCC_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define VCC_OFS_CLKOUT    8'hE4
`define VCC_OFS_CNT_CTRL  8'hE5
`define VCC_OFS_LATCH_CLR 8'hE6
`define VCC_OFS_CNT_BYTE  8'hE8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VCC_T1_RATE_MSB   7
`define VCC_T1_RATE_LSB   6
`define VCC_E1_RATE_MSB   5
`define VCC_E1_RATE_LSB   4
`define VCC_MON_SEL_BIT   7
`define VCC_READ_EN_BIT   6
`define VCC_CH_SEL_MSB    3
`define VCC_ALL_CLR_BIT   4
`define VCC_ALL_LATCH_BIT 3
`define VCC_BYTE_SEL_BIT  2
`define VCC_CH_LATCH_BIT  1
`define VCC_CH_CLR_BIT    0

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define VCC_RST_BYTE      8'h00
`define VCC_CORE_CLK_KHZ  64'd200000
`define VCC_T1_BASE_KHZ   64'd1544
`define VCC_E1_BASE_KHZ   64'd2048
`define VCC_CLR_HOLD_NS   1000
`define VCC_CLK_PERIOD_NS 5

`endif

// ==== rtl/vcc_pkg.sv ====
package vcc_pkg;
  typedef logic [7:0]  vcc_byte_t;
  typedef logic [15:0] vcc_count_t;
  typedef logic [3:0]  vcc_chsel_t;
  // multiple of the base reference rate
  typedef enum logic [1:0] {
    VCC_RATE_X1,
    VCC_RATE_X2,
    VCC_RATE_X4,
    VCC_RATE_X8
  } vcc_rate_t;
endpackage

// ==== rtl/vcc_lcv_counter.sv ====
`timescale 1ns/1ps
module vcc_lcv_counter #(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         viol,
  input  wire logic         clr,
  output logic [W-1:0]      count_r,
  output logic              sat
);

  assign sat = &count_r;

  // ----------------------------------------------------------------
  // saturating count
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst || clr) begin
      count_r <= '0;
    end else if (viol && !sat) begin
      count_r <= count_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sat_holds: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (sat && !clr) |=> (count_r == '1))
    else $error("saturated counter moved");

  a_clr_zeroes: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clr |=> (count_r == '0))
    else $error("clear did not zero counter");

  a_count_step: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (viol && !sat && !clr) |=> (count_r == $past(count_r) + 1'b1))
    else $error("violation not counted");

endmodule // vcc_lcv_counter

// ==== rtl/vcc_top.sv ====
// What this block does
// - t1 reference pin rate from bits 7:6
// - e1 reference pin rate from bits 5:4
// - 16-bit counter saturates and holds FFFFh
// - overflow flagged when counter saturated
// - monitor select picks violation or overflow
// - read enable gates counter byte readout
// - selector code minus one is channel
// - selector picks readout, latch and clear target
// - selector resets to none, code 0000
// - unused bits are plain storage, reset zero
// - clear zeroes counters; host holds 1us
// - channel latch copies live count to hold
// - byte select picks low or high byte
`timescale 1ns/1ps
`include "vcc_map.svh"
module vcc_top
  import vcc_pkg::*;
#(
  parameter int NCH = 14,
  parameter int CW  = 16
) (
  input  wire logic            core_clk,
  input  wire logic            sys_rst,
  input  wire logic [7:0]      host_addr,
  input  wire logic [7:0]      host_wdata,
  input  wire logic            host_wr,
  input  wire logic            host_rd,
  output logic      [7:0]      host_rdata,
  input  wire logic [NCH-1:0]  line_code_violation,
  output logic      [NCH-1:0]  monitor_status,
  output logic                 t1_ref_clock_pin,
  output logic                 e1_ref_clock_pin
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  // phase step so the accumulator msb runs at the base rate
  localparam logic [63:0] T1_STEP64 =
    (`VCC_T1_BASE_KHZ << 32) / `VCC_CORE_CLK_KHZ;
  localparam logic [63:0] E1_STEP64 =
    (`VCC_E1_BASE_KHZ << 32) / `VCC_CORE_CLK_KHZ;
  localparam logic [31:0] T1_STEP = T1_STEP64[31:0];
  localparam logic [31:0] E1_STEP = E1_STEP64[31:0];
  localparam int CLR_HOLD_CYC =
    `VCC_CLR_HOLD_NS / `VCC_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // selector decode
  // ----------------------------------------------------------------
  function automatic logic chan_ok(input vcc_chsel_t sel);
    chan_ok = (sel != 4'h0) && (sel <= 4'(NCH));
  endfunction

  function automatic logic [3:0] chan_idx(input vcc_chsel_t sel);
    chan_idx = sel - 4'h1;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  vcc_byte_t clkout_r;
  vcc_byte_t cnt_ctrl_r;
  vcc_byte_t latch_clr_r;
  logic      ch_latch_q_r;
  logic      all_latch_q_r;

  logic write_clkout;
  logic write_ctrl;
  logic write_latch;
  assign write_clkout = host_wr && (host_addr == `VCC_OFS_CLKOUT);
  assign write_ctrl   = host_wr && (host_addr == `VCC_OFS_CNT_CTRL);
  assign write_latch  = host_wr && (host_addr == `VCC_OFS_LATCH_CLR);

  // unused bits are kept as written with no function
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clkout_r <= `VCC_RST_BYTE;
    end else if (write_clkout) begin
      clkout_r <= host_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_ctrl_r <= `VCC_RST_BYTE;
    end else if (write_ctrl) begin
      cnt_ctrl_r <= host_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      latch_clr_r <= `VCC_RST_BYTE;
    end else if (write_latch) begin
      latch_clr_r <= host_wdata;
    end
  end

  vcc_rate_t  t1_ref_clock_rate_sel;
  vcc_rate_t  e1_ref_clock_rate_sel;
  logic       violation_or_overflow_monitor_sel;
  logic       violation_count_read_en;
  vcc_chsel_t violation_counter_channel_sel;
  logic       all_channel_count_clear;
  logic       all_channel_count_latch;
  logic       count_byte_sel;
  logic       channel_count_latch;
  logic       channel_count_clear;

  assign t1_ref_clock_rate_sel = vcc_rate_t'(
    clkout_r[`VCC_T1_RATE_MSB:`VCC_T1_RATE_LSB]);
  assign e1_ref_clock_rate_sel = vcc_rate_t'(
    clkout_r[`VCC_E1_RATE_MSB:`VCC_E1_RATE_LSB]);
  assign violation_or_overflow_monitor_sel = cnt_ctrl_r[`VCC_MON_SEL_BIT];
  assign violation_count_read_en = cnt_ctrl_r[`VCC_READ_EN_BIT];
  assign violation_counter_channel_sel = cnt_ctrl_r[`VCC_CH_SEL_MSB:0];
  assign all_channel_count_clear = latch_clr_r[`VCC_ALL_CLR_BIT];
  assign all_channel_count_latch = latch_clr_r[`VCC_ALL_LATCH_BIT];
  assign count_byte_sel          = latch_clr_r[`VCC_BYTE_SEL_BIT];
  assign channel_count_latch     = latch_clr_r[`VCC_CH_LATCH_BIT];
  assign channel_count_clear     = latch_clr_r[`VCC_CH_CLR_BIT];

  logic       sel_ok;
  logic [3:0] sel_idx;
  assign sel_ok  = chan_ok(violation_counter_channel_sel);
  assign sel_idx = chan_idx(violation_counter_channel_sel);

  // latch fires once per 0-to-1 write, not every cycle the bit stays set
  logic ch_latch_go;
  logic all_latch_go;
  assign ch_latch_go  = channel_count_latch && !ch_latch_q_r;
  assign all_latch_go = all_channel_count_latch && !all_latch_q_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ch_latch_q_r  <= 1'b0;
      all_latch_q_r <= 1'b0;
    end else begin
      ch_latch_q_r  <= channel_count_latch;
      all_latch_q_r <= all_channel_count_latch;
    end
  end

  // ----------------------------------------------------------------
  // counters and holding registers
  // ----------------------------------------------------------------
  logic [CW-1:0] live_cnt [NCH];
  logic [CW-1:0] hold_r   [NCH];
  logic [NCH-1:0] ovf;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic clr_this;
      // clear acts as long as the host keeps the bit set
      assign clr_this = all_channel_count_clear ||
        (channel_count_clear && sel_ok && (sel_idx == 4'(g)));

      vcc_lcv_counter #(
        .W (CW)
      ) u_cnt (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .viol     (line_code_violation[g]),
        .clr      (clr_this),
        .count_r  (live_cnt[g]),
        .sat      (ovf[g])
      );

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          hold_r[g] <= '0;
        end else if (all_latch_go ||
          (ch_latch_go && sel_ok && (sel_idx == 4'(g)))) begin
          hold_r[g] <= live_cnt[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // monitor status
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      monitor_status <= '0;
    end else if (violation_or_overflow_monitor_sel) begin
      monitor_status <= ovf;
    end else begin
      monitor_status <= line_code_violation;
    end
  end

  // ----------------------------------------------------------------
  // register readback
  // ----------------------------------------------------------------
  vcc_byte_t rd_mux;
  logic [CW-1:0] sel_hold;
  assign sel_hold = sel_ok ? hold_r[sel_idx] : '0;

  always_comb begin
    rd_mux = 8'h00;
    case (host_addr)
      `VCC_OFS_CLKOUT:    rd_mux = clkout_r;
      `VCC_OFS_CNT_CTRL:  rd_mux = cnt_ctrl_r;
      `VCC_OFS_LATCH_CLR: rd_mux = latch_clr_r;
      `VCC_OFS_CNT_BYTE: begin
        if (violation_count_read_en && sel_ok) begin
          rd_mux = count_byte_sel ? sel_hold[15:8] : sel_hold[7:0];
        end
      end
      default:            rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      host_rdata <= 8'h00;
    end else if (host_rd) begin
      host_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // reference clock synthesis
  // ----------------------------------------------------------------
  // fractional accumulators: edges jitter by one core period, which
  // is the price of running every rate off the single core clock
  logic [31:0] t1_acc_r;
  logic [31:0] e1_acc_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      t1_acc_r <= '0;
    end else begin
      t1_acc_r <= t1_acc_r + (T1_STEP << t1_ref_clock_rate_sel);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      e1_acc_r <= '0;
    end else begin
      e1_acc_r <= e1_acc_r + (E1_STEP << e1_ref_clock_rate_sel);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      t1_ref_clock_pin <= 1'b0;
      e1_ref_clock_pin <= 1'b0;
    end else begin
      t1_ref_clock_pin <= t1_acc_r[31];
      e1_ref_clock_pin <= e1_acc_r[31];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [7:0] clr_len_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !all_channel_count_clear) begin
      clr_len_r <= '0;
    end else if (clr_len_r != 8'hFF) begin
      clr_len_r <= clr_len_r + 8'h01;
    end
  end

  a_t1_step: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) |->
      t1_acc_r == $past(t1_acc_r) + (T1_STEP << $past(clkout_r[7:6])))
    else $error("t1 accumulator step wrong for rate");

  a_e1_step: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) |->
      e1_acc_r == $past(e1_acc_r) + (E1_STEP << $past(clkout_r[5:4])))
    else $error("e1 accumulator step wrong for rate");

  a_regs_reset: assert property (
    @(posedge core_clk)
    $past(sys_rst) |->
      (clkout_r == 8'h00 && cnt_ctrl_r == 8'h00 && !sel_ok))
    else $error("registers not cleared by reset");

  a_mon_follow: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ##1 monitor_status == ($past(cnt_ctrl_r[7]) ?
      $past(ovf) : $past(line_code_violation)))
    else $error("monitor status does not follow select");

  a_read_gated: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (host_rd && host_addr == `VCC_OFS_CNT_BYTE &&
      (!cnt_ctrl_r[6] || cnt_ctrl_r[3:0] == 4'h0 ||
       cnt_ctrl_r[3:0] == 4'hF)) |=> (host_rdata == 8'h00))
    else $error("counter byte readable while gated off");

  a_read_byte: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (host_rd && host_addr == `VCC_OFS_CNT_BYTE && cnt_ctrl_r[6] &&
      sel_ok) |=> (host_rdata == ($past(latch_clr_r[2]) ?
      $past(hold_r[sel_idx][15:8]) : $past(hold_r[sel_idx][7:0]))))
    else $error("wrong counter byte returned");

  a_latch_copy: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (ch_latch_go && sel_ok) |=> (hold_r[$past(sel_idx)] ==
      $past(live_cnt[sel_idx])))
    else $error("latch did not copy live count");

  a_clr_all: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    all_channel_count_clear |=> (live_cnt[0] == '0 &&
      live_cnt[NCH-1] == '0))
    else $error("clear all left a counter nonzero");

  a_clr_len: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clr_len_r == 8'(CLR_HOLD_CYC)) |-> (live_cnt[0] == '0))
    else $error("counter nonzero during held clear");

  c_high_byte: cover property (
    @(posedge core_clk) disable iff (sys_rst)
    host_rd && host_addr == `VCC_OFS_CNT_BYTE && sel_ok &&
      violation_count_read_en && count_byte_sel);

  c_overflow_mon: cover property (
    @(posedge core_clk) disable iff (sys_rst)
    violation_or_overflow_monitor_sel && (monitor_status != '0));

  c_latch_all: cover property (
    @(posedge core_clk) disable iff (sys_rst) all_latch_go);

  c_fast_t1: cover property (
    @(posedge core_clk) disable iff (sys_rst)
    t1_ref_clock_rate_sel == VCC_RATE_X8 && $rose(t1_ref_clock_pin));

endmodule // vcc_top

// ==== tb/vcc_host.sv ====
`timescale 1ns/1ps
`include "vcc_map.svh"
module vcc_host
  import vcc_pkg::*;
(
  input  wire logic       core_clk,
  output logic [7:0]      host_addr,
  output logic [7:0]      host_wdata,
  output logic            host_wr,
  output logic            host_rd,
  input  wire logic [7:0] host_rdata
);
  // ----------------------------------------------------------------
  // idle bus
  // ----------------------------------------------------------------
  initial begin
    host_addr  = 8'h00;
    host_wdata = 8'h00;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
  end

  // ----------------------------------------------------------------
  // one-cycle strobes, launched just after an edge
  // ----------------------------------------------------------------
  task automatic wr(input vcc_byte_t a, input vcc_byte_t d);
    @(posedge core_clk);
    #1;
    host_addr  = a;
    host_wdata = d;
    host_wr    = 1'b1;
    @(posedge core_clk);
    #1;
    host_wr    = 1'b0;
    // released data shows the inverse so stale values never look valid
    host_wdata = ~d;
  endtask

  task automatic rd(input vcc_byte_t a, output vcc_byte_t d);
    @(posedge core_clk);
    #1;
    host_addr = a;
    host_rd   = 1'b1;
    @(posedge core_clk);
    #1;
    host_rd   = 1'b0;
    // read data holds until the next read, so one more edge is safe
    @(posedge core_clk);
    #1;
    d = host_rdata;
  endtask

  // clear bits stay set for a full microsecond before release
  task automatic clr_hold(input vcc_byte_t bits);
    wr(`VCC_OFS_LATCH_CLR, bits);
    repeat (200) @(posedge core_clk);
    wr(`VCC_OFS_LATCH_CLR, 8'h00);
  endtask
endmodule // vcc_host

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "vcc_map.svh"
module tb_top
  import vcc_pkg::*;
;
  logic        core_clk;
  logic        sys_rst;
  logic [7:0]  host_addr;
  logic [7:0]  host_wdata;
  logic        host_wr;
  logic        host_rd;
  logic [7:0]  host_rdata;
  logic [13:0] lcv;
  logic [13:0] monitor_status;
  logic        t1;
  logic        e1;
  vcc_byte_t   d;
  int          n_errors;
  int          tests_run;
  int          cyc;

`define CHK(nm, ex, got) begin \
  tests_run++; \
  if ((got) !== (ex)) begin \
    n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); \
  end \
end

  vcc_top #(.NCH(14), .CW(16)) dut (
    .core_clk            (core_clk),
    .sys_rst             (sys_rst),
    .host_addr           (host_addr),
    .host_wdata          (host_wdata),
    .host_wr             (host_wr),
    .host_rd             (host_rd),
    .host_rdata          (host_rdata),
    .line_code_violation (lcv),
    .monitor_status      (monitor_status),
    .t1_ref_clock_pin    (t1),
    .e1_ref_clock_pin    (e1)
  );

  vcc_host host (
    .core_clk   (core_clk),
    .host_addr  (host_addr),
    .host_wdata (host_wdata),
    .host_wr    (host_wr),
    .host_rd    (host_rd),
    .host_rdata (host_rdata)
  );

  // ----------------------------------------------------------------
  // clock, reset and run limit
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // saturation alone needs about 66k cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic viol(input int ch, input int n);
    @(posedge core_clk);
    #1;
    lcv[ch] = 1'b1;
    repeat (n) @(posedge core_clk);
    #1;
    lcv[ch] = 1'b0;
  endtask

  // phase accumulators jitter by one period, so allow one edge slack
  task automatic rates(input int code);
    int nt, ne, et, ee;
    logic pt, pe;
    host.wr(`VCC_OFS_CLKOUT, 8'(code * 8'h50 + 8'h05));
    repeat (100) @(posedge core_clk);
    // sample pins only once the edge's register updates have landed
    #1;
    nt = 0;
    ne = 0;
    pt = t1;
    pe = e1;
    repeat (2000) begin
      @(posedge core_clk);
      #1;
      if (t1 && !pt) nt++;
      if (e1 && !pe) ne++;
      pt = t1;
      pe = e1;
    end
    et = 1544 * (1 << code) * 2000 / 200000;
    ee = 2048 * (1 << code) * 2000 / 200000;
    `CHK("t1 rate", 1'b1, (nt >= et - 1 && nt <= et + 1))
    `CHK("e1 rate", 1'b1, (ne >= ee - 1 && ne <= ee + 1))
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    lcv     = 14'h0000;
    repeat (4) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    `CHK("t1 pin rst", 1'b0, t1)
    `CHK("e1 pin rst", 1'b0, e1)
    `CHK("mon rst", 14'h0000, monitor_status)
    host.rd(`VCC_OFS_CLKOUT, d);
    `CHK("clkout rst", 8'h00, d)
    host.rd(`VCC_OFS_CNT_CTRL, d);
    `CHK("cnt ctrl rst", 8'h00, d)
    host.wr(`VCC_OFS_CLKOUT, 8'h0A);
    host.rd(`VCC_OFS_CLKOUT, d);
    `CHK("clkout spare", 8'h0A, d)
    host.wr(`VCC_OFS_CNT_CTRL, 8'h30);
    host.rd(`VCC_OFS_CNT_CTRL, d);
    `CHK("ctrl spare", 8'h30, d)
    host.rd(8'h10, d);
    `CHK("unmapped", 8'h00, d)
    for (int c = 0; c < 4; c++) rates(c);
    // monitor shows raw activity one cycle late
    host.wr(`VCC_OFS_CNT_CTRL, 8'h43);
    @(posedge core_clk);
    #1;
    lcv[5] = 1'b1;
    @(posedge core_clk);
    #1;
    lcv[5] = 1'b0;
    `CHK("mon lcv", 14'h0020, monitor_status)
    viol(2, 5);
    host.wr(`VCC_OFS_LATCH_CLR, 8'h02);
    host.wr(`VCC_OFS_LATCH_CLR, 8'h00);
    host.rd(`VCC_OFS_CNT_BYTE, d);
    `CHK("ch2 low", 8'h05, d)
    host.wr(`VCC_OFS_LATCH_CLR, 8'h04);
    host.rd(`VCC_OFS_CNT_BYTE, d);
    `CHK("ch2 high", 8'h00, d)
    host.wr(`VCC_OFS_LATCH_CLR, 8'h00);
    host.wr(`VCC_OFS_CNT_CTRL, 8'h03);
    host.rd(`VCC_OFS_CNT_BYTE, d);
    `CHK("read off", 8'h00, d)
    host.wr(`VCC_OFS_CNT_CTRL, 8'h4F);
    host.rd(`VCC_OFS_CNT_BYTE, d);
    `CHK("sel 1111", 8'h00, d)
    // channel 0 runs past full scale
    host.wr(`VCC_OFS_CNT_CTRL, 8'hC1);
    viol(0, 65540);
    @(posedge core_clk);
    #1;
    `CHK("ovf mon", 14'h0001, monitor_status)
    host.wr(`VCC_OFS_LATCH_CLR, 8'h02);
    host.wr(`VCC_OFS_LATCH_CLR, 8'h00);
    host.rd(`VCC_OFS_CNT_BYTE, d);
    `CHK("sat low", 8'hFF, d)
    host.wr(`VCC_OFS_LATCH_CLR, 8'h04);
    host.rd(`VCC_OFS_CNT_BYTE, d);
    `CHK("sat high", 8'hFF, d)
    // code 0000 must stay dark even though channel 0 now holds FFFF
    host.wr(`VCC_OFS_CNT_CTRL, 8'h40);
    host.rd(`VCC_OFS_CNT_BYTE, d);
    `CHK("sel 0000", 8'h00, d)
    host.wr(`VCC_OFS_CNT_CTRL, 8'hC1);
    host.clr_hold(8'h01);
    `CHK("ovf gone", 14'h0000, monitor_status)
    host.wr(`VCC_OFS_LATCH_CLR, 8'h02);
    host.wr(`VCC_OFS_LATCH_CLR, 8'h00);
    host.rd(`VCC_OFS_CNT_BYTE, d);
    `CHK("cleared", 8'h00, d)
    // channel 2 still holds 5 counts; add 3 and take them with latch all
    viol(2, 3);
    host.wr(`VCC_OFS_LATCH_CLR, 8'h08);
    host.wr(`VCC_OFS_LATCH_CLR, 8'h00);
    host.wr(`VCC_OFS_CNT_CTRL, 8'h43);
    host.rd(`VCC_OFS_CNT_BYTE, d);
    `CHK("latch all", 8'h08, d)
    host.clr_hold(8'h10);
    host.wr(`VCC_OFS_LATCH_CLR, 8'h08);
    host.wr(`VCC_OFS_LATCH_CLR, 8'h00);
    host.rd(`VCC_OFS_CNT_BYTE, d);
    `CHK("clear all", 8'h00, d)
    end_sim();
  end
endmodule // tb_top
